// ==== logic/lle_cfg.svh ====
// register offsets, field positions, reset values and limits
// assumes byte addresses on an AXI4-Lite bus with 32-bit data
`ifndef LLE_CFG_SVH
`define LLE_CFG_SVH
`define OFS_CTRL   6'h00
`define OFS_COEF   6'h01
`define OFS_THR    6'h02
`define OFS_SPLIT  6'h03
`define OFS_ROWS   6'h04
`define OFS_STAT   6'h05
`define MSK_CTRL   32'h0000_007F
`define MSK_COEF   32'h3FFF_FFFF
`define MSK_THR    32'h0000_00FF
`define MSK_HALF   32'h0000_FFFF
`define RST_CTRL   32'h0000_0000
`define RST_COEF   32'h0010_0401
`define RST_THR    32'h0000_0000
`define RST_SPLIT  32'h0000_0000
`define RST_ROWS   32'h0000_0100
`define F_FILT     0
`define F_CORE     1
`define F_METH     3:2
`define F_FINE     4
`define F_RAW      5
`define F_WIDE     6
`define W_MAX      12'h200
`define LIM_NARROW 16'h00FF
`define FB_COARSE  4'h5
`define FB_FINE    4'h8
`define COLS       8192
`define RESP_OK    2'h0
`define RESP_ERR   2'h2
`endif

// ==== logic/lle_core.sv ====
// laser line extraction core: filter, coring, column-wise extraction
// assumes pixels arrive raster order on CLK, results always accepted
`timescale 1ns/1ns
`include "lle_cfg.svh"
// Operation
// - maximum mode emits 8-bit or 16-bit integer results
// - narrow maximum covers heights to 255, wide to 65535
// - equal maximum intensities: the highest row position wins
// - maximum gives zero when position too high or column empty
// - invalid marker is all zeros in every mode
// - valid results are never zero
// - peak results are 16-bit unsigned fixed point, two precisions
// - coarse precision: 11 integer bits, 5 fraction bits
// - fine precision: 8 integer bits, 8 fraction bits
// - several peaks: brightest wins, ties to highest row
// - gravity results use the same two fixed-point precisions
// - several gravity runs: brightest wins, ties to highest row
// - peak and gravity give zero when too high or no line
// - gravity gives zero when its running sum overflows
// - input pixels are 8-bit monochrome only
// - nonzero split row enables dual-line mode at that row
// - each region yields exactly one line
// - output is depth map or raw image, never both
// - optional three-tap filter with weights A, B, C
// - weight sum must be 1 to 512
// - taps outside the region take the centre pixel
// - coring passes values above threshold, else zero
// - regions up to 8192 columns wide
// - the two regions are processed independently
// - one result per column per region per frame
module lle_core (
  // clock and reset
  input  wire logic          CLK,
  input  wire logic          RST_N,
  // register bus
  input  wire logic          AWVALID,
  output wire logic          AWREADY,
  input  wire logic [7:0]    AWADDR,
  input  wire logic          WVALID,
  output wire logic          WREADY,
  input  wire logic [31:0]   WDATA,
  input  wire logic [3:0]    WSTRB,
  output logic               BVALID,
  input  wire logic          BREADY,
  output logic [1:0]         BRESP,
  input  wire logic          ARVALID,
  output wire logic          ARREADY,
  input  wire logic [7:0]    ARADDR,
  output logic               RVALID,
  input  wire logic          RREADY,
  output logic [31:0]        RDATA,
  output logic [1:0]         RRESP,
  // camera pixels
  input  wire logic          PIX_VALID,
  output wire logic          PIX_READY,
  input  wire lle_pkg::pix_s PIX,
  // results toward dma
  output logic               RES_VALID,
  output lle_pkg::res_s      RES
);
  import lle_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1;
  logic rst_n;
  // two-stage release of the async reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // fixed-point quotient (num << fb) / den
  function automatic logic [31:0] ratio(input logic [31:0] num,
                                        input logic [16:0] den,
                                        input logic [3:0]  fb);
    logic [39:0] sh;
    sh = {8'h00, num} << fb;
    ratio = (den == 17'h0) ? 32'h0 : 32'(sh / {23'h0, den});
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    for (int i = 0; i < 4; i++)
      merge[8*i+:8] = s[i] ? n[8*i+:8] : o[8*i+:8];
  endfunction

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic        aw_got;
  logic        w_got;
  logic [5:0]  aw_idx;
  logic [31:0] w_dat;
  logic [3:0]  w_stb;
  logic [31:0] ctrl;
  logic [31:0] coef;
  logic [31:0] thr;
  logic [31:0] split;
  logic [31:0] rows;
  logic [15:0] frame_cnt;
  logic [15:0] row;
  logic        do_wr;
  logic        wr_hit;

  assign AWREADY = !aw_got && !BVALID;
  assign WREADY  = !w_got && !BVALID;
  assign ARREADY = !RVALID;
  assign do_wr   = aw_got && w_got && !BVALID;
  assign wr_hit  = aw_idx <= `OFS_ROWS;

  // write address and data, taken in either order
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_idx <= 6'h00;
      w_dat  <= 32'h0000_0000;
      w_stb  <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got <= 1'b1;
        aw_idx <= AWADDR[7:2];
      end
      if (WVALID && WREADY) begin
        w_got <= 1'b1;
        w_dat <= WDATA;
        w_stb <= WSTRB;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
      end
    end
  end

  // write response, error for unmapped words
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      BVALID <= 1'b0;
      BRESP  <= `RESP_OK;
    end else if (do_wr) begin
      BVALID <= 1'b1;
      BRESP  <= wr_hit ? `RESP_OK : `RESP_ERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // configuration words
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl  <= `RST_CTRL;
      coef  <= `RST_COEF;
      thr   <= `RST_THR;
      split <= `RST_SPLIT;
      rows  <= `RST_ROWS;
    end else if (do_wr) begin
      unique case (aw_idx)
        `OFS_CTRL:  ctrl  <= merge(ctrl, w_dat, w_stb) & `MSK_CTRL;
        `OFS_COEF:  coef  <= merge(coef, w_dat, w_stb) & `MSK_COEF;
        `OFS_THR:   thr   <= merge(thr, w_dat, w_stb) & `MSK_THR;
        `OFS_SPLIT: split <= merge(split, w_dat, w_stb) & `MSK_HALF;
        `OFS_ROWS:  rows  <= merge(rows, w_dat, w_stb) & `MSK_HALF;
        default:    ;
      endcase
    end
  end

  // read answer one cycle after the address
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= `RESP_OK;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP  <= `RESP_OK;
      unique case (ARADDR[7:2])
        `OFS_CTRL:  RDATA <= ctrl;
        `OFS_COEF:  RDATA <= coef;
        `OFS_THR:   RDATA <= thr;
        `OFS_SPLIT: RDATA <= split;
        `OFS_ROWS:  RDATA <= rows;
        `OFS_STAT:  RDATA <= {frame_cnt, row};
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= `RESP_ERR;
        end
      endcase
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // linear filter
  // ----------------------------------------
  logic        filt_en;
  logic        core_en;
  logic        raw;
  logic        fine;
  logic        wide;
  method_e     meth;
  logic [7:0]  l_px;
  logic [7:0]  c_px;
  logic        c_have;
  logic        c_first;
  logic        c_last;
  logic        c_sof;
  logic        take;
  logic        emit;
  logic [7:0]  lt;
  logic [7:0]  rt;
  logic [19:0] wacc;
  logic [11:0] wsum;
  logic [7:0]  filt;
  logic [7:0]  cored;

  assign filt_en = ctrl[`F_FILT];
  assign core_en = ctrl[`F_CORE];
  assign raw     = ctrl[`F_RAW];
  assign fine    = ctrl[`F_FINE];
  assign wide    = ctrl[`F_WIDE];
  assign meth    = (ctrl[`F_METH] == 2'h0) ? M_MAX :
                   (ctrl[`F_METH] == 2'h1) ? M_PEAK : M_COG;

  // stall one cycle after a line's last pixel to flush it
  assign PIX_READY = !(c_have && c_last);
  assign take      = PIX_VALID && PIX_READY;
  assign emit      = (take && c_have) || (c_have && c_last);

  // outer taps replaced by the centre at line ends
  assign lt   = c_first ? c_px : l_px;
  assign rt   = c_last ? c_px : PIX.data;
  assign wsum = {2'h0, coef[9:0]} + {2'h0, coef[19:10]} + {2'h0, coef[29:20]};
  assign wacc = {10'h0, coef[9:0]} * {12'h0, lt}
              + {10'h0, coef[19:10]} * {12'h0, c_px}
              + {10'h0, coef[29:20]} * {12'h0, rt};
  // out-of-range weights leave the pixel untouched
  assign filt = (filt_en && wsum != 12'h0 && wsum <= `W_MAX) ?
                8'(ratio({12'h0, wacc}, {5'h0, wsum}, 4'h0)) : c_px;
  assign cored = (!core_en || filt > thr[7:0]) ? filt : 8'h00;

  // sliding window of three pixels
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      l_px    <= 8'h00;
      c_px    <= 8'h00;
      c_have  <= 1'b0;
      c_first <= 1'b0;
      c_last  <= 1'b0;
      c_sof   <= 1'b0;
    end else if (take) begin
      l_px    <= c_px;
      c_px    <= PIX.data;
      c_have  <= 1'b1;
      c_first <= !c_have;
      c_last  <= PIX.eol;
      c_sof   <= PIX.sof;
    end else if (c_have && c_last) begin
      c_have <= 1'b0;
    end
  end

  // filtered and cored pixel toward extraction
  logic       fv;
  logic [7:0] fpx;
  logic [7:0] fraw;
  logic       flast;
  logic       fsof;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      fv    <= 1'b0;
      fpx   <= 8'h00;
      fraw  <= 8'h00;
      flast <= 1'b0;
      fsof  <= 1'b0;
    end else begin
      fv    <= emit;
      fpx   <= cored;
      fraw  <= c_px;
      flast <= c_last;
      fsof  <= c_sof && c_first;
    end
  end

  // ----------------------------------------
  // column-wise extraction
  // ----------------------------------------
  col_s        mem [0:`COLS-1];
  logic [12:0] col;
  logic [12:0] x;
  logic [15:0] y;
  logic        dual;
  logic        reg1;
  logic [15:0] ry;
  logic [15:0] pos;
  logic        rlast;
  col_s        st;
  col_s        ns;
  logic [16:0] pden;
  logic [31:0] pnum;
  logic [16:0] tsum;
  logic [31:0] tmom;
  logic [7:0]  tpk;
  logic        tovf;
  logic        run_end;
  logic        pk_eval;
  logic [31:0] dnum;
  logic [16:0] dden;
  logic [31:0] q;
  logic [15:0] qres;
  logic [15:0] res_word;

  assign x     = fsof ? 13'h0 : col;
  assign y     = fsof ? 16'h0 : row;
  assign dual  = split[15:0] != 16'h0;
  assign reg1  = dual && y >= split[15:0];
  assign ry    = reg1 ? y - split[15:0] : y;
  assign pos   = ry + 16'h1;
  assign rlast = (y == rows[15:0] - 16'h1) ||
                 (dual && y == split[15:0] - 16'h1);
  // a region's first row starts from a clean column
  assign st    = (ry == 16'h0) ? '0 : mem[x];

  // three-point centroid around a local maximum
  assign pden = {9'h0, st.pa} + {9'h0, st.pc} + {9'h0, fpx};
  assign pnum = {16'h0, ry} * {15'h0, pden} + {24'h0, fpx} - {24'h0, st.pa};
  assign pk_eval = st.pend && fpx <= st.pc;

  // running run of lit pixels for the gravity centre
  assign tsum = {1'b0, st.run_sum} + {9'h0, fpx};
  assign tmom = st.run_mom + {24'h0, fpx} * {16'h0, pos};
  assign tpk  = (fpx > st.run_pk) ? fpx : st.run_pk;
  assign tovf = st.run_ovf || tsum[16];
  assign run_end = (fpx == 8'h00 && st.run_sum != 16'h0) ||
                   (rlast && fpx != 8'h00);

  // one shared divider, fed by the active method
  assign dnum = (meth == M_PEAK) ? pnum :
                (fpx == 8'h00) ? st.run_mom : tmom;
  assign dden = (meth == M_PEAK) ? pden :
                (fpx == 8'h00) ? {1'b0, st.run_sum} : tsum;
  assign q    = ratio(dnum, dden, fine ? `FB_FINE : `FB_COARSE);
  assign qres = (q > 32'h0000_FFFF) ? 16'h0 : q[15:0];

  // next column state
  always_comb begin
    ns = st;
    ns.prev = fpx;
    unique case (meth)
      M_MAX: begin
        if (fpx != 8'h00 && fpx >= st.best_i) begin
          ns.best_i   = fpx;
          ns.best_res = pos;
          ns.found    = 1'b1;
        end
      end
      M_PEAK: begin
        if (pk_eval && st.pc >= st.best_i) begin
          ns.best_i   = st.pc;
          ns.best_res = qres;
          ns.found    = 1'b1;
        end
        ns.pend = fpx != 8'h00 && fpx >= st.prev;
        ns.pa   = st.prev;
        ns.pc   = fpx;
      end
      M_COG: begin
        if (fpx != 8'h00) begin
          ns.run_sum = tsum[15:0];
          ns.run_mom = tmom;
          ns.run_pk  = tpk;
          ns.run_ovf = tovf;
        end
        if (run_end) begin
          if (tpk >= st.best_i) begin
            ns.best_i   = tpk;
            ns.best_res = tovf ? 16'h0 : qres;
            ns.found    = 1'b1;
          end
          ns.run_sum = 16'h0;
          ns.run_mom = 32'h0;
          ns.run_pk  = 8'h00;
          ns.run_ovf = 1'b0;
        end
      end
    endcase
  end

  // final word of a column, zero when nothing valid
  always_comb begin
    res_word = ns.found ? ns.best_res : 16'h0;
    if (meth == M_MAX && !wide && res_word > `LIM_NARROW)
      res_word = 16'h0;
  end

  // column memory update
  always_ff @(posedge CLK) begin
    if (fv)
      mem[x] <= ns;
  end

  // raster position and frame count
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      col       <= 13'h0;
      row       <= 16'h0;
      frame_cnt <= 16'h0;
    end else if (fv) begin
      col <= flast ? 13'h0 : x + 13'h1;
      row <= flast ? y + 16'h1 : y;
      if (fsof)
        frame_cnt <= frame_cnt + 16'h1;
    end
  end

  // result words on a region's last row, or raw pixels
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RES_VALID <= 1'b0;
      RES       <= '0;
    end else begin
      RES_VALID  <= fv && (raw || rlast);
      RES.region <= reg1;
      RES.last   <= flast;
      RES.data   <= raw ? {8'h00, fraw} : res_word;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_raw_passes: assert property (fv && raw |=> RES_VALID &&
    RES.data == {8'h00, $past(fraw)}) else $error("raw pixel lost");
  a_narrow_range: assert property (fv && rlast && !raw && meth == M_MAX &&
    !wide |=> RES.data[15:8] == 8'h00) else $error("narrow word too wide");
  a_empty_zero: assert property (fv && rlast && !raw && !ns.found
    |=> RES_VALID && RES.data == 16'h0) else $error("empty column not zero");
  a_tie_high: assert property (fv && meth == M_MAX && fpx != 8'h00 &&
    fpx == st.best_i |-> ns.best_res == pos) else $error("tie not highest");
  a_core_zero: assert property (emit && core_en && filt <= thr[7:0]
    |=> fv && fpx == 8'h00) else $error("coring leaked");
  a_stage_pass: assert property (emit && !filt_en && !core_en
    |=> fpx == $past(c_px)) else $error("disabled stages altered");
  a_edge_stall: assert property (c_have && c_last |-> !PIX_READY
    ##1 !c_have) else $error("line end not flushed");
  a_split_reg: assert property (fv && dual && y == split[15:0]
    |-> reg1 && pos == 16'h1) else $error("split row wrong");
  a_ovf_zero: assert property (fv && meth == M_COG && run_end && tovf
    && tpk >= st.best_i |-> ns.best_res == 16'h0) else $error("overflow kept");

  c_dual: cover property (fv && reg1 && rlast);
  c_peak: cover property (fv && meth == M_PEAK && pk_eval);
  c_ovf: cover property (fv && meth == M_COG && tovf && run_end);
  c_raw: cover property (RES_VALID && raw);
endmodule

// ==== logic/lle_pkg.sv ====
// types shared by the laser line extraction core
// assumes lle_cfg.svh carries all numeric constants
package lle_pkg;
  typedef enum logic [2:0] {
    M_MAX  = 3'h1,
    M_PEAK = 3'h2,
    M_COG  = 3'h4
  } method_e;
  typedef struct packed {
    logic       sof;
    logic       eol;
    logic [7:0] data;
  } pix_s;
  typedef struct packed {
    logic        region;
    logic        last;
    logic [15:0] data;
  } res_s;
  typedef struct packed {
    logic [7:0]  prev;
    logic [7:0]  best_i;
    logic [15:0] best_res;
    logic        found;
    logic        pend;
    logic [7:0]  pa;
    logic [7:0]  pc;
    logic [7:0]  run_pk;
    logic [15:0] run_sum;
    logic [31:0] run_mom;
    logic        run_ovf;
  } col_s;
endpackage

// ==== test/laser_line_extraction_core_test.sv ====
// self-checking bench for the laser line extraction core
// assumes lle_cfg.svh on the include path, lle_cam_src compiled first
`timescale 1ns/1ns
`include "lle_cfg.svh"
module laser_line_extraction_core_test;
  import lle_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        AWVALID = 1'b0;
  logic        WVALID = 1'b0;
  logic        ARVALID = 1'b0;
  logic        BREADY = 1'b1;
  logic        RREADY = 1'b1;
  logic [7:0]  AWADDR = 8'h00;
  logic [7:0]  ARADDR = 8'h00;
  logic [3:0]  WSTRB = 4'hF;
  logic [31:0] WDATA = 32'h0;
  logic [31:0] seed = 32'h605B;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic        PIX_VALID, PIX_READY, RES_VALID;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] RDATA, ctrl, coef, thr, split;
  pix_s        PIX;
  res_s        RES;
  res_s        eq[$];
  logic [7:0]  img[0:299][0:3];
  int          W, H;
  int          miscompares = 0;
  int          compares = 0;

  always #2 CLK = ~CLK;

  lle_core dut (.CLK(CLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
    .PIX(PIX), .RES_VALID(RES_VALID), .RES(RES));

  lle_cam_src src (.CLK(CLK), .PIX_READY(PIX_READY), .PIX_VALID(PIX_VALID), .PIX(PIX));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      stop_test();
    end
  endtask

  // each result word is matched against the oldest note
  always @(posedge CLK) begin
    if (RES_VALID === 1'b1) begin
      if (eq.size() == 0)
        chk(RES, 32'hFFFF_FFFF);
      else
        chk(RES, eq.pop_front());
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ----------------------------------------
  // register bus master
  // ----------------------------------------
  task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    AWADDR <= {i, 2'h0};
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID && n < 300);
    guard(n, 300);
    chk(BRESP, e);
  endtask

  task automatic rd(input logic [5:0] i, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    ARADDR <= {i, 2'h0};
    ARVALID <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID && n < 300);
    guard(n, 300);
    chk(RDATA, e);
    chk(RRESP, er);
  endtask

  // ----------------------------------------
  // reference model and frames
  // ----------------------------------------
  // filter then coring of one pixel, edges take the centre
  function automatic logic [7:0] pv(input int r, input int c);
    logic [7:0]  l, m, x, v;
    logic [11:0] s;
    logic [19:0] n;
    m = img[r][c];
    l = (c > 0) ? img[r][c-1] : m;
    x = (c < W - 1) ? img[r][c+1] : m;
    s = coef[9:0] + coef[19:10] + coef[29:20];
    n = coef[9:0] * l + coef[19:10] * m + coef[29:20] * x;
    v = m;
    if (ctrl[`F_FILT] && s >= 12'h001 && s <= `W_MAX) v = 8'(n / s);
    if (ctrl[`F_CORE] && v <= thr[7:0]) v = 8'h00;
    return v;
  endfunction

  task automatic expect_frame();
    int r0, r1, p, ps, bv, fb, pk, a, b;
    logic [31:0] d, q, rs, rm, rp;
    fb = ctrl[`F_FINE] ? 8 : 5;
    if (ctrl[`F_RAW]) begin
      for (int r = 0; r < H; r++)
        for (int c = 0; c < W; c++)
          eq.push_back({1'b0, c == W - 1, 8'h00, img[r][c]});
      return;
    end
    for (int g = 0; g < ((split != 0) ? 2 : 1); g++) begin
      r0 = g ? split : 0;
      r1 = (g || split == 0) ? H - 1 : split - 1;
      for (int c = 0; c < W; c++) begin
        bv = 0;
        d = 0;
        rs = 0;
        rm = 0;
        rp = 0;
        for (int r = r0; r <= r1; r++) begin
          p = pv(r, c);
          ps = r - r0 + 1;
          // above the region's first row counts as dark
          a = (r > r0) ? pv(r - 1, c) : 0;
          b = (r < r1) ? pv(r + 1, c) : 0;
          pk = r < r1 && p >= a && p >= b;
          if (ctrl[3:2] == 2'h0 && p > 0 && p >= bv) begin
            bv = p;
            d = ps;
          end
          if (ctrl[3:2] == 2'h1 && pk && p > 0 && p >= bv) begin
            bv = p;
            // three-point centroid in the chosen fixed point
            d = ((ps * (a + p + b) + b - a) << fb) / (a + p + b);
          end
          if (ctrl[3] && p > 0) begin
            rs += p;
            rm += ps * p;
            if (p > rp) rp = p;
          end
          if (ctrl[3] && (p == 0 || r == r1) && rs > 0) begin
            q = (rm << fb) / rs;
            if (rp >= bv) begin
              bv = rp;
              d = (rs > 65535) ? 0 : q;
            end
            rs = 0;
            rm = 0;
            rp = 0;
          end
        end
        if (ctrl[3:2] == 2'h0 && !ctrl[`F_WIDE] && d > `LIM_NARROW) d = 0;
        if (d > 65535) d = 0;
        eq.push_back({g[0], c == W - 1, d[15:0]});
      end
    end
  endtask

  task automatic fill(input int w, input int h);
    logic [31:0] v;
    W = w;
    H = h;
    for (int r = 0; r < h; r++)
      for (int c = 0; c < w; c++) begin
        v = xs();
        img[r][c] = v[7:0];
      end
  endtask

  // one column of eight rows, one hex digit per row
  task automatic col(input int c, input logic [31:0] h);
    for (int r = 0; r < 8; r++) img[r][c] = {4'h0, h[31-4*r -: 4]};
  endtask

  task automatic run();
    int n;
    wr(`OFS_CTRL, ctrl, `RESP_OK);
    wr(`OFS_COEF, coef, `RESP_OK);
    wr(`OFS_THR, thr, `RESP_OK);
    wr(`OFS_SPLIT, split, `RESP_OK);
    wr(`OFS_ROWS, 32'(H), `RESP_OK);
    expect_frame();
    for (int r = 0; r < H; r++)
      for (int c = 0; c < W; c++)
        src.q.push_back({r == 0 && c == 0, c == W - 1, img[r][c]});
    n = 0;
    while ((eq.size() > 0 || src.q.size() > 0) && n < 5000) begin
      @(posedge CLK);
      n++;
    end
    guard(n, 5000);
    repeat (8) @(posedge CLK);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    // reset values, unmapped and read-only places, reserved bits
    rd(`OFS_CTRL, `RST_CTRL, `RESP_OK);
    rd(`OFS_COEF, `RST_COEF, `RESP_OK);
    rd(`OFS_THR, `RST_THR, `RESP_OK);
    rd(`OFS_SPLIT, `RST_SPLIT, `RESP_OK);
    rd(`OFS_ROWS, `RST_ROWS, `RESP_OK);
    rd(6'h06, 32'h0, `RESP_ERR);
    wr(6'h06, 32'h1, `RESP_ERR);
    wr(`OFS_STAT, 32'h1, `RESP_ERR);
    wr(`OFS_THR, 32'hFFFF_FFFF, `RESP_OK);
    rd(`OFS_THR, `MSK_THR, `RESP_OK);
    coef = `RST_COEF;
    thr = 32'h0;
    split = 32'h0;
    // raw image words only
    ctrl = 32'h20;
    fill(4, 2);
    run();
    // filtered and cored maximum with a dim pair of columns
    ctrl = 32'h03;
    coef = {2'h0, 10'h002, 10'h005, 10'h002};
    thr = 32'h14;
    fill(4, 4);
    for (int r = 0; r < 4; r++) begin
      img[r][0] = 8'h0A;
      img[r][1] = 8'h0A;
    end
    run();
    ctrl = 32'h00;
    run();
    // tall frame: height limits, ties at the bottom, sum overflow
    W = 2;
    H = 300;
    for (int r = 0; r < 300; r++) begin
      img[r][0] = 8'hFF;
      img[r][1] = (r == 254) ? 8'h09 : 8'h00;
    end
    run();
    ctrl = 32'h40;
    run();
    ctrl = 32'h08;
    run();
    // two regions split at row 3, far side stalling
    src.slow = 1'b1;
    split = 32'h3;
    ctrl = 32'h41;
    coef = {2'h0, 10'h200, 10'h001, 10'h001};
    fill(4, 6);
    run();
    split = 32'h0;
    // peak and gravity on hand-made columns
    W = 4;
    H = 8;
    col(0, 32'h0282_8380);
    col(1, 32'h0000_0000);
    col(2, 32'h0015_1000);
    col(3, 32'h0141_1710);
    ctrl = 32'h04;
    run();
    ctrl = 32'h14;
    run();
    ctrl = 32'h18;
    run();
    // ten frames seen, row counter past the last line
    rd(`OFS_STAT, 32'h000A_0008, `RESP_OK);
    stop_test();
  end
endmodule

// ==== test/lle_cam_src.sv ====
// camera side model: offers queued pixels to the extraction core
// assumes the bench fills q between frames, same clock as the core
`timescale 1ns/1ns
module lle_cam_src (
  // clock
  input  wire logic     CLK,
  // pixel stream
  input  wire logic     PIX_READY,
  output logic          PIX_VALID,
  output lle_pkg::pix_s PIX
);
  import lle_pkg::*;
  // ----------------------------------------
  // pixel offer
  // ----------------------------------------
  pix_s       q[$];
  logic       slow = 1'b0;
  logic [1:0] k = 2'h0;
  initial begin
    PIX_VALID = 1'b0;
    PIX = '0;
  end
  // hold each pixel until taken; idle data toggles so stale values never pass
  always @(posedge CLK) begin
    k <= k + 2'h1;
    if (!PIX_VALID || PIX_READY) begin
      if (q.size() > 0 && !(slow && k[0])) begin
        PIX <= q.pop_front();
        PIX_VALID <= 1'b1;
      end else begin
        PIX_VALID <= 1'b0;
        PIX <= ~PIX;
      end
    end
  end
endmodule
